// ### rtl/cem_channel_monitor.sv
// channel error handling, ss7 message filter and signal unit error monitor
`timescale 1ns/1ns
`include "cem_regs.svh"
module cem_channel_monitor #(
   parameter int GOLD_BYTES = 7,
   parameter int FLY_WIDTH = 10
) (
   input wire logic i_clock,
   input wire logic i_rst,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // line interface pins, asynchronous
   input wire logic i_link_clock,
   input wire logic i_receive_frame_sync,
   input wire logic i_loss_of_frame,
   // fifo state from the data path
   input wire logic i_tx_fifo_empty,
   input wire logic i_tx_buffer_owned,
   input wire logic i_rx_fifo_full,
   input wire logic i_rx_buffer_owned,
   // received message stream from the hdlc engine
   input wire logic i_msg_byte_valid,
   input wire logic [7:0] i_msg_byte,
   input wire logic i_msg_end,
   input wire logic i_short_frame_error,
   input wire logic i_octet_align_error,
   input wire logic i_crc_error,
   input wire logic i_seven_ones,
   input wire logic i_long_frame_error,
   // channel control toward the data path
   output logic o_tx_send_idle,
   output logic o_tx_bus_stop,
   output logic o_rx_bus_stop,
   output logic o_rx_fifo_flush,
   output logic o_rx_force_ones,
   output logic o_filter_hold_buffer,
   output logic o_inter_system_link_mode,
   output logic [5:0] o_signal_unit_error_counter,
   // interrupt descriptor toward the queue writer
   output logic o_desc_valid,
   output logic [3:0] o_desc_code,
   output logic o_desc_dir,
   input wire logic i_desc_ready
);
   // lowest pending event, the order of service
   function automatic logic [3:0] lowest_set(input logic [11:0] vec);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = 11; i >= 0; i--)
         if (vec[i])
            idx = 4'(i);
      return idx;
   endfunction
   // last flywheel count of a frame for the port mode
   function automatic logic [FLY_WIDTH-1:0] frame_last(input logic [2:0] mode);
      logic [FLY_WIDTH-1:0] last;
      case (mode)
         cem_pkg::CEM_MODE_T1: last = FLY_WIDTH'(`CEM_T1_LAST);
         cem_pkg::CEM_MODE_E1: last = FLY_WIDTH'(`CEM_E1_LAST);
         cem_pkg::CEM_MODE_E1X2: last = FLY_WIDTH'(`CEM_E1X2_LAST);
         default: last = FLY_WIDTH'(`CEM_E1X4_LAST);
      endcase
      return last;
   endfunction
   // software state
   logic [3:0] ctrl; // abort select and port mode
   logic [22:0] chcfg; // fcs, protocol, threshold, masks
   // pin synchronisers: bit 0 clock, 1 sync, 2 loss of frame
   logic [2:0] pin_s1, pin_s2, pin_s3, pin_f, pin_prev;
   // channel state
   logic tx_susp, rx_susp, locked;
   logic [FLY_WIDTH-1:0] fly_count;
   logic [11:0] pending;
   // message filter state
   logic [7:0] cap [GOLD_BYTES];
   logic [7:0] gold [GOLD_BYTES];
   logic [3:0] cap_cnt, gold_len;
   logic filter_mode, mismatch;
   // leaky bucket state
   logic octet_mode;
   logic [3:0] bad_cnt;
   logic [7:0] good_cnt;
   logic [5:0] errs;
   // apb decode, zero wait states, unmapped offsets answer slverr
   wire setup_phase = i_psel & ~i_penable;
   wire access_phase = i_psel & i_penable;
   wire hit_ctrl = i_paddr == `CEM_CTRL_OFS;
   wire hit_chcfg = i_paddr == `CEM_CHCFG_OFS;
   wire hit_status = i_paddr == `CEM_STATUS_OFS;
   wire hit_count = i_paddr == `CEM_COUNT_OFS;
   wire addr_ok = hit_ctrl | hit_chcfg | hit_status | hit_count;
   wire wr_ctrl = access_phase & i_pwrite & hit_ctrl;
   wire wr_chcfg = access_phase & i_pwrite & hit_chcfg;
   assign o_pready = access_phase;
   assign o_pslverr = access_phase & ~addr_ok;
   // configuration fields
   wire abort_sel = ctrl[`CEM_CTRL_ABORT_BIT];
   wire [2:0] port_mode = ctrl[`CEM_CTRL_MODE_MSB:`CEM_CTRL_MODE_LSB];
   wire [1:0] fcs_sel = chcfg[`CEM_CHCFG_FCS_MSB:`CEM_CHCFG_FCS_LSB];
   wire [1:0] proto_sel = chcfg[`CEM_CHCFG_PROTO_MSB:`CEM_CHCFG_PROTO_LSB];
   wire [5:0] thresh = chcfg[`CEM_CHCFG_THRESH_MSB:`CEM_CHCFG_THRESH_LSB];
   wire [6:0] int_mask = chcfg[`CEM_CHCFG_MASK_MSB:`CEM_CHCFG_MASK_LSB];
   wire isl_mode = fcs_sel == `CEM_FCS_ISL && proto_sel == `CEM_PROTO_ISL;
   wire ss7_mode = fcs_sel == `CEM_FCS_CRC16 && proto_sel == `CEM_PROTO_SS7;
   wire framed = port_mode inside {cem_pkg::CEM_MODE_T1, cem_pkg::CEM_MODE_E1,
      cem_pkg::CEM_MODE_E1X2, cem_pkg::CEM_MODE_E1X4};
   // reactivation: control pulse bits, or any write of the channel table for rx
   wire tx_react = wr_ctrl & i_pwdata[`CEM_CTRL_TX_REACT_BIT];
   wire rx_react = (wr_ctrl & i_pwdata[`CEM_CTRL_RX_REACT_BIT]) | wr_chcfg;
   // filtered pin levels and their edges
   wire link_rise = pin_f[0] & ~pin_prev[0];
   wire sync_rise = pin_f[1] & ~pin_prev[1];
   wire loss_rise = pin_f[2] & ~pin_prev[2];
   // transmit underflow, judged at each bit demand of the link
   wire tx_starve = link_rise & ~tx_susp & i_tx_fifo_empty & i_tx_buffer_owned;
   // receive overflow, split by who owns the next buffer
   wire rx_over = link_rise & ~rx_susp & i_rx_fifo_full;
   wire rx_starve = rx_over & i_rx_buffer_owned;
   wire rx_owner = rx_over & ~i_rx_buffer_owned;
   // sync rising away from the frame boundary after lock
   wire fly_edge = fly_count == frame_last(port_mode) || fly_count == '0;
   wire align_change = framed & sync_rise & locked & ~fly_edge;
   wire rx_abort_hit = abort_sel & (align_change | loss_rise);
   // message classification
   wire msg_bad = i_short_frame_error | i_octet_align_error | i_crc_error;
   wire msg_good = i_msg_end & ~msg_bad & ~i_long_frame_error;
   wire cap_fits = cap_cnt >= `CEM_GOLD_MIN && cap_cnt <= `CEM_GOLD_MAX;
   wire qualifies = ss7_mode & msg_good & cap_fits;
   wire byte_miss = cap_cnt >= gold_len || i_msg_byte != gold[cap_cnt[2:0]];
   wire miss_now = filter_mode & i_msg_byte_valid & byte_miss;
   wire filter_match = ss7_mode & filter_mode & i_msg_end & ~mismatch
      & ~miss_now & cap_cnt == gold_len;
   wire filter_exit = mismatch | miss_now | (i_msg_end & cap_cnt != gold_len);
   // leaky bucket events
   wire octet_wrap = octet_mode & i_msg_byte_valid & bad_cnt == 4'hf;
   wire bucket_inc = ss7_mode & ((i_msg_end & msg_bad) | octet_wrap);
   wire bucket_dec = ss7_mode & msg_good & good_cnt == 8'hff;
   wire do_inc = bucket_inc & ~bucket_dec & errs != 6'h3f;
   wire do_dec = bucket_dec & ~bucket_inc & errs != 6'h00;
   wire [5:0] next_errs = do_inc ? errs + 6'h01 : do_dec ? errs - 6'h01 : errs;
   wire hit_thresh = bucket_inc & next_errs >= thresh;
   // maskable events, a set mask bit suppresses the descriptor
   wire [6:0] masked_raw = {hit_thresh, bucket_dec, bucket_inc,
      ss7_mode & i_msg_end & i_crc_error, ss7_mode & i_msg_end & i_octet_align_error,
      ss7_mode & i_msg_end & i_short_frame_error, filter_match};
   wire [11:0] ev_set = {masked_raw & ~int_mask, loss_rise, align_change,
      rx_owner, rx_starve, tx_starve};
   // descriptor register reloads when empty or when taken
   wire desc_free = ~o_desc_valid | i_desc_ready;
   wire desc_load = desc_free & (pending != 12'h000);
   wire [3:0] desc_pick = lowest_set(pending);
   wire [11:0] desc_clear = desc_load ? 12'h001 << desc_pick : 12'h000;
   // register writes
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         ctrl <= `CEM_CTRL_RESET;
         chcfg <= `CEM_CHCFG_RESET | ({17'h0, `CEM_THRESH_RESET} << `CEM_CHCFG_THRESH_LSB);
      end
      else
      begin
         if (wr_ctrl)
            ctrl <= i_pwdata[3:0];
         if (wr_chcfg)
            chcfg <= i_pwdata[22:0];
      end
   end
   // read data is captured in the setup phase so it comes from a flop
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         o_prdata <= 32'h00000000;
      else if (setup_phase)
      begin
         case (1'b1)
            hit_ctrl: o_prdata <= {28'h0, ctrl};
            hit_chcfg: o_prdata <= {9'h0, chcfg};
            hit_status: o_prdata <= {4'h0, pending, 10'h0, locked, octet_mode,
               filter_mode, o_rx_force_ones, rx_susp, tx_susp};
            hit_count: o_prdata <= {8'h0, good_cnt, 4'h0, bad_cnt, 2'h0, errs};
            default: o_prdata <= 32'h00000000;
         endcase
      end
   end
   // three stage pin sampling; stage one feeds only stage two
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         pin_s1 <= 3'h0;
         pin_s2 <= 3'h0;
         pin_s3 <= 3'h0;
         pin_f <= 3'h0;
         pin_prev <= 3'h0;
      end
      else
      begin
         pin_s1 <= {i_loss_of_frame, i_receive_frame_sync, i_link_clock};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         // a level is accepted only when stages two and three agree
         pin_f <= (pin_s3 & ~(pin_s2 ^ pin_s3)) | (pin_f & (pin_s2 ^ pin_s3));
         pin_prev <= pin_f;
      end
   end
   // frame flywheel, counts link bits and realigns on sync
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         fly_count <= '0;
         locked <= 1'b0;
      end
      else if (!framed)
         locked <= 1'b0; // unframed port has no alignment to lose
      else if (sync_rise)
      begin
         fly_count <= '0;
         locked <= 1'b1;
      end
      else if (link_rise)
         fly_count <= fly_count == frame_last(port_mode) ? '0 : fly_count + 1'b1;
   end
   // suspend flags; a new error outranks a reactivation in the same cycle
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         tx_susp <= 1'b0;
         rx_susp <= 1'b0;
         o_rx_fifo_flush <= 1'b0;
      end
      else
      begin
         tx_susp <= tx_starve | (tx_susp & ~tx_react);
         rx_susp <= rx_over | rx_abort_hit | (rx_susp & ~rx_react);
         // discard the fifo on overflow, loss of frame, or aborted realignment
         o_rx_fifo_flush <= rx_over | loss_rise | (abort_sel & align_change);
      end
   end
   // pending descriptors; set wins over the service clear
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         pending <= 12'h000;
         o_desc_valid <= 1'b0;
         o_desc_code <= 4'h0;
         o_desc_dir <= 1'b0;
      end
      else
      begin
         pending <= (pending & ~desc_clear) | ev_set;
         if (desc_free)
            o_desc_valid <= desc_load;
         if (desc_load)
         begin
            o_desc_code <= desc_pick;
            o_desc_dir <= desc_pick == cem_pkg::CEM_EV_TX_STARVE;
         end
      end
   end
   // capture the current message bytes and count them, saturating at eight
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         cap_cnt <= 4'h0;
      else if (i_msg_end)
         cap_cnt <= 4'h0;
      else if (i_msg_byte_valid && cap_cnt != 4'h8)
         cap_cnt <= cap_cnt + 4'h1;
   end
   // byte store has no reset, it is only read under a valid count
   always_ff @(posedge i_clock)
   begin
      if (i_msg_byte_valid && cap_cnt < 4'(GOLD_BYTES))
         cap[cap_cnt[2:0]] <= i_msg_byte;
      if (qualifies && (!filter_mode || filter_exit))
         gold <= cap;
   end
   // filter mode: enter on a qualifying message, leave on first mismatch
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         filter_mode <= 1'b0;
         mismatch <= 1'b0;
         gold_len <= 4'h0;
      end
      else if (!ss7_mode)
      begin
         filter_mode <= 1'b0;
         mismatch <= 1'b0;
      end
      else
      begin
         // the mismatch flag spans one message only
         mismatch <= i_msg_end ? 1'b0 : (mismatch | miss_now);
         if (qualifies && (!filter_mode || filter_exit))
         begin
            filter_mode <= 1'b1;
            gold_len <= cap_cnt;
         end
         else if (filter_mode && (miss_now || (i_msg_end && filter_exit)))
            filter_mode <= 1'b0;
      end
   end
   // leaky bucket counters
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         octet_mode <= 1'b0;
         bad_cnt <= 4'h0;
         good_cnt <= 8'h00;
         errs <= 6'h00;
      end
      else if (ss7_mode)
      begin
         errs <= next_errs;
         if (i_seven_ones || i_long_frame_error)
         begin
            octet_mode <= 1'b1;
            bad_cnt <= 4'h0;
         end
         else if (octet_mode && msg_good)
            octet_mode <= 1'b0;
         else if (octet_mode && i_msg_byte_valid)
            bad_cnt <= bad_cnt + 4'h1;
         // good count is held in octet mode and resumes from the good exit message
         if (msg_good)
            good_cnt <= good_cnt + 8'h01;
      end
   end
   // outputs toward the data path
   assign o_tx_send_idle = tx_susp;
   assign o_tx_bus_stop = tx_susp;
   assign o_rx_bus_stop = rx_susp;
   assign o_rx_force_ones = pin_f[2] & ~abort_sel & ~rx_susp;
   assign o_filter_hold_buffer = filter_mode;
   assign o_inter_system_link_mode = isl_mode;
   assign o_signal_unit_error_counter = errs;
endmodule

// ### rtl/cem_pkg.sv
// types shared by the channel monitor
package cem_pkg;

   // port framing of the serial group
   typedef enum logic [2:0] {
      CEM_MODE_NX64 = 3'h0,
      CEM_MODE_T1 = 3'h1,
      CEM_MODE_E1 = 3'h2,
      CEM_MODE_E1X2 = 3'h3,
      CEM_MODE_E1X4 = 3'h4
   } cem_port_mode_type;

   // interrupt descriptor codes, also the bit index of the pending vector
   typedef enum logic [3:0] {
      CEM_EV_TX_STARVE = 4'h0,
      CEM_EV_RX_STARVE = 4'h1,
      CEM_EV_RX_OWNER = 4'h2,
      CEM_EV_ALIGN_CHANGE = 4'h3,
      CEM_EV_LOSS_OF_FRAME = 4'h4,
      CEM_EV_FILTER_MATCH = 4'h5,
      CEM_EV_SHORT = 4'h6,
      CEM_EV_OCTET_ALIGN = 4'h7,
      CEM_EV_CRC = 4'h8,
      CEM_EV_COUNT_UP = 4'h9,
      CEM_EV_COUNT_DOWN = 4'ha,
      CEM_EV_THRESHOLD = 4'hb
   } cem_event_type;

endpackage

// ### rtl/cem_regs.svh
// register offsets, field positions, reset values and link counts of the channel monitor
`ifndef CEM_REGS_SVH
`define CEM_REGS_SVH

// apb byte offsets, one aligned word each
`define CEM_CTRL_OFS 12'h000
`define CEM_CHCFG_OFS 12'h004
`define CEM_STATUS_OFS 12'h008
`define CEM_COUNT_OFS 12'h00c

// control register fields
`define CEM_CTRL_ABORT_BIT 0
`define CEM_CTRL_MODE_LSB 1
`define CEM_CTRL_MODE_MSB 3
`define CEM_CTRL_TX_REACT_BIT 8
`define CEM_CTRL_RX_REACT_BIT 9

// channel configuration fields
`define CEM_CHCFG_FCS_LSB 0
`define CEM_CHCFG_FCS_MSB 1
`define CEM_CHCFG_PROTO_LSB 2
`define CEM_CHCFG_PROTO_MSB 3
`define CEM_CHCFG_THRESH_LSB 8
`define CEM_CHCFG_THRESH_MSB 13
`define CEM_CHCFG_MASK_LSB 16
`define CEM_CHCFG_MASK_MSB 22

// field encodings
`define CEM_FCS_CRC16 2'h0
`define CEM_FCS_ISL 2'h1
`define CEM_PROTO_SS7 2'h1
`define CEM_PROTO_ISL 2'h2

// reset values
`define CEM_CTRL_RESET 4'h0
`define CEM_CHCFG_RESET 23'h000000
`define CEM_THRESH_RESET 6'h3f

// last bit index of one frame per port mode
`define CEM_T1_LAST 10'd192
`define CEM_E1_LAST 10'd255
`define CEM_E1X2_LAST 10'd511
`define CEM_E1X4_LAST 10'd1023

// golden message bounds, payload plus two check octets
`define CEM_GOLD_MIN 4'd5
`define CEM_GOLD_MAX 4'd7

`endif

// ### verif/cem_channel_monitor_props.sv
// port level checker of the channel monitor
`timescale 1ns/1ns
module cem_channel_monitor_props (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic o_pready,
   input wire logic i_desc_ready,
   input wire logic o_desc_valid,
   input wire logic [3:0] o_desc_code,
   input wire logic o_desc_dir,
   input wire logic o_tx_send_idle,
   input wire logic o_tx_bus_stop,
   input wire logic o_rx_bus_stop,
   input wire logic o_rx_fifo_flush,
   input wire logic o_rx_force_ones,
   input wire logic o_filter_hold_buffer,
   input wire logic [5:0] o_signal_unit_error_counter
);
   // single clock domain
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // short alias of the leaky bucket value
   logic [5:0] cnt;
   assign cnt = o_signal_unit_error_counter;
   // zero wait state slave
   a_zero_wait: assert property (i_psel && i_penable |-> o_pready)
      else $error("access phase without ready");
   a_desc_held: assert property (
      o_desc_valid && !i_desc_ready |=> o_desc_valid && $stable(o_desc_code) && $stable(o_desc_dir))
      else $error("descriptor dropped before acceptance");
   a_desc_dir: assert property (
      o_desc_valid |-> o_desc_dir == (o_desc_code == 4'h0))
      else $error("descriptor direction wrong");
   a_tx_idle_stop: assert property (o_tx_send_idle == o_tx_bus_stop)
      else $error("idle code and bus stop disagree");
   a_tx_starve_desc: assert property (
      $rose(o_tx_send_idle) |-> ##[0:4] (o_desc_valid && o_desc_code == 4'h0))
      else $error("tx suspend without starve descriptor");
   a_flush_pulse: assert property (o_rx_fifo_flush |=> !o_rx_fifo_flush)
      else $error("flush longer than one cycle");
   a_rx_stop_desc: assert property (
      $rose(o_rx_bus_stop) |-> ##[0:4] (o_desc_valid && !o_desc_dir))
      else $error("rx suspend without receive descriptor");
   a_ones_active: assert property (o_rx_force_ones |-> !o_rx_bus_stop)
      else $error("ones forced while suspended");
   a_count_step: assert property (
      !$stable(cnt) |-> cnt == $past(cnt) + 6'h01 || cnt == $past(cnt) - 6'h01)
      else $error("error counter jumped");
   a_count_up_irq: assert property (
      cnt == $past(cnt) + 6'h01 |-> ##[1:10] (o_desc_valid && o_desc_code == 4'h9))
      else $error("increment without count up descriptor");
   a_count_down_irq: assert property (
      cnt == $past(cnt) - 6'h01 |-> ##[1:10] (o_desc_valid && o_desc_code == 4'ha))
      else $error("decrement without count down descriptor");
   // main scenarios reached
   c_tx_starve: cover property ($rose(o_tx_send_idle));
   c_filter: cover property ($rose(o_filter_hold_buffer));
   c_count_down: cover property (cnt == $past(cnt) - 6'h01);
endmodule
bind cem_channel_monitor cem_channel_monitor_props cem_channel_monitor_props_i (.*);

// ### verif/cem_channel_monitor_tb_top.sv
// self checking bench of the channel monitor
`timescale 1ns/1ns
`include "cem_regs.svh"
module cem_channel_monitor_tb_top;
   logic i_clock = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h00000000, o_prdata, rd;
   logic i_tx_fifo_empty = 1'b0, i_tx_buffer_owned = 1'b0;
   logic i_rx_fifo_full = 1'b0, i_rx_buffer_owned = 1'b0;
   logic i_msg_byte_valid = 1'b0, i_msg_end = 1'b0, i_seven_ones = 1'b0;
   logic [7:0] i_msg_byte = 8'h00;
   logic i_short_frame_error = 1'b0, i_octet_align_error = 1'b0, i_crc_error = 1'b0;
   logic i_long_frame_error = 1'b0, i_desc_ready = 1'b1;
   logic i_link_clock, i_receive_frame_sync, i_loss_of_frame, perr;
   logic o_pready, o_pslverr, o_tx_send_idle, o_tx_bus_stop, o_rx_bus_stop, o_rx_fifo_flush;
   logic o_rx_force_ones, o_filter_hold_buffer, o_inter_system_link_mode, o_desc_valid, o_desc_dir;
   logic [5:0] o_signal_unit_error_counter;
   logic [3:0] o_desc_code;
   // seen holds accepted descriptor codes, slot 15 a flush pulse
   logic [15:0] seen = 16'h0000, dirs = 16'h0000;
   int errors = 0, checks = 0, cycles = 0, n;
   cem_channel_monitor cem_channel_monitor_i (.i_clock, .i_rst, .i_psel, .i_penable, .i_pwrite,
      .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_link_clock, .i_receive_frame_sync,
      .i_loss_of_frame, .i_tx_fifo_empty, .i_tx_buffer_owned, .i_rx_fifo_full, .i_rx_buffer_owned,
      .i_msg_byte_valid, .i_msg_byte, .i_msg_end, .i_short_frame_error, .i_octet_align_error,
      .i_crc_error, .i_seven_ones, .i_long_frame_error, .o_tx_send_idle, .o_tx_bus_stop,
      .o_rx_bus_stop, .o_rx_fifo_flush, .o_rx_force_ones, .o_filter_hold_buffer,
      .o_inter_system_link_mode, .o_signal_unit_error_counter, .o_desc_valid, .o_desc_code,
      .o_desc_dir, .i_desc_ready);
   cem_line_model cem_line_model_i (.o_link_clock(i_link_clock),
      .o_receive_frame_sync(i_receive_frame_sync), .o_loss_of_frame(i_loss_of_frame));
   // 10 mhz system clock
   always #50 i_clock = ~i_clock;
   // descriptor log and hang guard
   always @(posedge i_clock)
   begin
      cycles <= cycles + 1;
      if (o_desc_valid === 1'b1)
      begin
         seen[o_desc_code] <= 1'b1;
         dirs[o_desc_code] <= o_desc_dir;
      end
      if (o_rx_fifo_flush === 1'b1)
         seen[15] <= 1'b1;
      if (cycles == 20000)
      begin
         errors++;
         tally_and_finish();
      end
   end
   // one counted compare
   task check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; data and error flag taken at the ready edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge i_clock);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clock);
      i_penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge i_clock);
         k++;
      end
      while (o_pready !== 1'b1 && k < 16);
      if (k == 16)
         errors++;
      rd = o_prdata;
      perr = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      // let the write land before anyone looks
      @(negedge i_clock);
   endtask
   task rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h00000000);
      check(rd, e);
   endtask
   // wait a bounded time for a descriptor code, then compare it and its direction
   task expect_desc(input int c, input logic d);
      for (int i = 0; i < 200 && seen[c] !== 1'b1; i++)
         @(posedge i_clock);
      check(seen[c], 1'b1);
      check(dirs[c], d);
   endtask
   // octets of a message, then the closing flag with error qualifiers if fin
   task msg(input logic [63:0] d, input int len, input logic [2:0] e, input logic fin);
      for (int i = 0; i < len; i++)
      begin
         @(posedge i_clock);
         i_msg_byte_valid <= 1'b1;
         i_msg_byte <= d[8 * (i % 8) +: 8];
      end
      @(posedge i_clock);
      i_msg_byte_valid <= 1'b0;
      i_msg_end <= fin;
      {i_crc_error, i_octet_align_error, i_short_frame_error} <= e;
      @(posedge i_clock);
      i_msg_end <= 1'b0;
      {i_crc_error, i_octet_align_error, i_short_frame_error} <= 3'h0;
      repeat (4) @(posedge i_clock);
      @(negedge i_clock);
   endtask
   // verdict, in one place
   task tally_and_finish();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge i_clock);
      i_rst <= 1'b0;
      // let the pin filters settle
      repeat (4) @(posedge i_clock);
      rdchk(`CEM_CTRL_OFS, 32'h00000000);
      rdchk(`CEM_CHCFG_OFS, 32'h00003f00);
      rdchk(12'h010, 32'h00000000);
      check(perr, 1'b1);
      apb(1'b1, `CEM_CHCFG_OFS, 32'h00000009);
      check(o_inter_system_link_mode, 1'b1);
      apb(1'b1, `CEM_CHCFG_OFS, 32'h0000000a);
      check(o_inter_system_link_mode, 1'b0);
      // an empty fifo facing a host owned buffer is not a starve
      @(posedge i_clock);
      i_tx_fifo_empty <= 1'b1;
      repeat (40) @(posedge i_clock);
      check(o_tx_send_idle, 1'b0);
      i_tx_buffer_owned <= 1'b1;
      expect_desc(0, 1'b1);
      @(negedge i_clock);
      check({o_tx_send_idle, o_tx_bus_stop}, 2'h3);
      @(posedge i_clock);
      i_tx_fifo_empty <= 1'b0;
      apb(1'b1, `CEM_CTRL_OFS, 32'h00000100);
      check(o_tx_send_idle, 1'b0);
      // rx overflow into an owned buffer, then into a host owned one
      for (int k = 1; k >= 0; k--)
      begin
         seen = 16'h0000;
         @(posedge i_clock);
         i_rx_buffer_owned <= k[0];
         i_rx_fifo_full <= 1'b1;
         expect_desc(k ? 1 : 2, 1'b0);
         check({seen[15], o_rx_bus_stop}, 2'h3);
         @(posedge i_clock);
         i_rx_fifo_full <= 1'b0;
         apb(1'b1, k ? `CEM_CHCFG_OFS : `CEM_CTRL_OFS, k ? 32'h0000000a : 32'h00000200);
         check(o_rx_bus_stop, 1'b0);
      end
      // early sync in every port mode, abort select alternating
      for (int m = 0; m < 5; m++)
      begin
         apb(1'b1, `CEM_CTRL_OFS, 32'h00000200);
         seen = 16'h0000;
         apb(1'b1, `CEM_CTRL_OFS, {28'h0000000, m[2:0], m[0]});
         cem_line_model_i.sync_pulse();
         repeat (20) @(posedge i_link_clock);
         cem_line_model_i.sync_pulse();
         repeat (40) @(posedge i_clock);
         check(seen[3], m != 0);
         check(o_rx_bus_stop, m != 0 && m[0]);
      end
      // loss of frame, abort clear: ones stored, resumes alone
      apb(1'b1, `CEM_CTRL_OFS, 32'h00000204);
      seen = 16'h0000;
      cem_line_model_i.set_frame_loss(1'b1);
      expect_desc(4, 1'b0);
      check({seen[15], o_rx_force_ones}, 2'h3);
      cem_line_model_i.set_frame_loss(1'b0);
      repeat (20) @(posedge i_clock);
      check(o_rx_force_ones, 1'b0);
      // abort set: suspend with no ones until the host restarts
      apb(1'b1, `CEM_CTRL_OFS, 32'h00000005);
      cem_line_model_i.set_frame_loss(1'b1);
      repeat (40) @(posedge i_clock);
      check({o_rx_bus_stop, o_rx_force_ones}, 2'h2);
      cem_line_model_i.set_frame_loss(1'b0);
      apb(1'b1, `CEM_CTRL_OFS, 32'h00000205);
      check(o_rx_bus_stop, 1'b0);
      // ss7 crc16 channel, threshold 2, nothing masked
      apb(1'b1, `CEM_CHCFG_OFS, 32'h00000204);
      msg(64'h0000000504030201, 5, 3'h0, 1'b1);
      check(o_filter_hold_buffer, 1'b1);
      seen = 16'h0000;
      msg(64'h0000000504030201, 5, 3'h0, 1'b1);
      check({seen[5], o_filter_hold_buffer}, 2'h3);
      msg(64'h0807060504030201, 8, 3'h0, 1'b1);
      check(o_filter_hold_buffer, 1'b0);
      msg(64'h0000161514131211, 6, 3'h0, 1'b1);
      check(o_filter_hold_buffer, 1'b1);
      msg(64'h0000000504030201, 5, 3'h0, 1'b1);
      seen = 16'h0000;
      msg(64'h0000000504030201, 5, 3'h0, 1'b1);
      check({seen[5], o_filter_hold_buffer}, 2'h3);
      // crc, short and alignment ends each bump the bucket
      seen = 16'h0000;
      msg(64'h0000000000000077, 2, 3'h4, 1'b1);
      check({seen[8], seen[9], o_signal_unit_error_counter}, 8'hc1);
      msg(64'h0000000000000077, 2, 3'h1, 1'b1);
      check({seen[6], seen[11], o_signal_unit_error_counter}, 8'hc2);
      msg(64'h0000000000000077, 2, 3'h2, 1'b1);
      check({seen[7], o_signal_unit_error_counter}, 7'h43);
      // seven ones opens octet counting; the sixteenth octet bumps the bucket
      @(posedge i_clock);
      i_seven_ones <= 1'b1;
      @(posedge i_clock);
      i_seven_ones <= 1'b0;
      msg(64'h0000000000000000, 15, 3'h0, 1'b0);
      check(o_signal_unit_error_counter, 6'h03);
      msg(64'h0000000000000000, 1, 3'h0, 1'b0);
      check(o_signal_unit_error_counter, 6'h04);
      apb(1'b0, `CEM_COUNT_OFS, 32'h00000000);
      check(rd & 32'h00ff003f, 32'h00060004);
      // good messages leak the bucket once per 256
      seen = 16'h0000;
      n = 0;
      while (o_signal_unit_error_counter === 6'h04 && n < 300)
      begin
         msg(64'h0000000000000033, 1, 3'h0, 1'b1);
         n++;
      end
      check(n == 250 || n == 251, 1'b1);
      check({seen[10], o_signal_unit_error_counter}, 7'h43);
      tally_and_finish();
   end
endmodule

// ### verif/cem_line_model.sv
// line interface model: link clock, frame sync and loss of frame pins
`timescale 1ns/1ns
module cem_line_model (
   output logic o_link_clock,
   output logic o_receive_frame_sync,
   output logic o_loss_of_frame
);
   // a t1/e1 line clock runs free, also between frames
   initial o_link_clock = 1'b0;
   always #400 o_link_clock = ~o_link_clock;
   // pins start idle and in frame
   initial
   begin
      o_receive_frame_sync = 1'b0;
      o_loss_of_frame = 1'b0;
   end
   // one bit wide sync, launched on the falling edge so it is steady at the rising one
   task sync_pulse();
      @(negedge o_link_clock);
      o_receive_frame_sync = 1'b1;
      @(negedge o_link_clock);
      o_receive_frame_sync = 1'b0;
   endtask
   // framer verdict changes on a bit boundary
   task set_frame_loss(input logic v);
      @(negedge o_link_clock);
      o_loss_of_frame = v;
   endtask
endmodule
